/* File: dv/test_metering_register_bank_slice.sv */
// Purpose: Self-checking bench for the metering register slice
// Assumes: AXI4-Lite master in bench, short averaging window
// Notes:   Model keeps register images in an associative array
`timescale 1ns/100ps

module test_metering_register_bank_slice;

   localparam int AVG_N = 8;
   localparam int MEAS_W = $bits(mrb_pkg::mrb_meas_s);

   logic               aclk;
   logic               aresetn;
   logic [17:0]        s_axi_awaddr;
   logic               s_axi_awvalid;
   logic               s_axi_awready;
   logic [31:0]        s_axi_wdata;
   logic [3:0]         s_axi_wstrb;
   logic               s_axi_wvalid;
   logic               s_axi_wready;
   logic [1:0]         s_axi_bresp;
   logic               s_axi_bvalid;
   logic               s_axi_bready;
   logic [17:0]        s_axi_araddr;
   logic               s_axi_arvalid;
   logic               s_axi_arready;
   logic [31:0]        s_axi_rdata;
   logic [1:0]         s_axi_rresp;
   logic               s_axi_rvalid;
   logic               s_axi_rready;
   mrb_pkg::mrb_meas_s meas;
   logic [2:0]         applied_voltage_rms_in;
   mrb_pkg::mrb_cfg_s  cfg;
   int                 errors;
   int                 checks_done;
   int                 seed;
   logic [31:0]        mdl [logic [15:0]];
   logic [15:0]        rw_l [4];
   logic [15:0]        ro_l [20];

   mrb_top #(.AVG_LEN(AVG_N)) dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .meas(meas),
      .applied_voltage_rms_in(applied_voltage_rms_in), .cfg(cfg));

   // Free-running 10 MHz clock
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   // Hang guard, far beyond the expected run length
   initial
   begin
      repeat (20000) @(posedge aclk);
      errors++;
      complete_run();
   end

   task automatic complete_run();
      if (errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Write master: address and data offered together, bready held until bvalid
   task automatic wr(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] r);
      logic a;
      logic w;
      a = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (1)
      begin
         @(posedge aclk);
         if (!a && s_axi_awready)
         begin
            a = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready)
         begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
         if (a && w && s_axi_bvalid)
         begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask

   // Read master: rready held until rvalid
   task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
      logic a;
      a = 1'b0;
      @(posedge aclk);
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (1)
      begin
         @(posedge aclk);
         if (!a && s_axi_arready)
         begin
            a = 1'b1;
            s_axi_arvalid <= 1'b0;
         end
         if (a && s_axi_rvalid)
         begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask

   // Writable width per register; zero means the write is refused
   function automatic logic [31:0] wmask(input logic [15:0] i);
      case (i)
         mrb_pkg::IDX_NOMV:  return 32'h00ffffff;
         mrb_pkg::IDX_LCYC, mrb_pkg::IDX_ZXTO, mrb_pkg::IDX_COMP: return 32'h0000ffff;
         mrb_pkg::IDX_NOMEN: return 32'h00000007;
         default:            return 32'h00000000;
      endcase
   endfunction

   // Expected read word: narrow values zero padded, unmapped reads zero
   function automatic logic [31:0] exp_rd(input logic [15:0] i);
      if (mdl.exists(i))
         return mdl[i];
      case (i)
         mrb_pkg::IDX_IA_AVG: return {8'h00, meas.i_rms_a};
         mrb_pkg::IDX_VA_AVG: return {8'h00, meas.v_rms_a};
         mrb_pkg::IDX_IB_AVG: return {8'h00, meas.i_rms_b};
         mrb_pkg::IDX_VB_AVG: return {8'h00, meas.v_rms_b};
         mrb_pkg::IDX_IC_AVG: return {8'h00, meas.i_rms_c};
         mrb_pkg::IDX_VC_AVG: return {8'h00, meas.v_rms_c};
         mrb_pkg::IDX_IN_AVG: return {8'h00, meas.i_rms_n};
         mrb_pkg::IDX_PEAK:   return {16'h0000, meas.peak_status};
         mrb_pkg::IDX_DLY0:   return {16'h0000, meas.dly0};
         mrb_pkg::IDX_DLY1:   return {16'h0000, meas.dly1};
         mrb_pkg::IDX_DLY2:   return {16'h0000, meas.dly2};
         mrb_pkg::IDX_PERIOD: return {16'h0000, meas.period};
         mrb_pkg::IDX_NOLOAD: return {16'h0000, meas.noload};
         default:             return 32'h00000000;
      endcase
   endfunction

   // Main sequence
   initial
   begin
      logic [31:0] d;
      logic [31:0] v;
      logic [1:0]  r;
      logic [1:0]  er;
      seed = 4;
      errors = 0;
      checks_done = 0;
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      // Constant live values so every averaging window yields the same word
      meas = MEAS_W'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
              $random(seed), $random(seed), $random(seed), $random(seed)});
      applied_voltage_rms_in = 3'($random(seed));
      rw_l = '{mrb_pkg::IDX_NOMV, mrb_pkg::IDX_LCYC, mrb_pkg::IDX_ZXTO, mrb_pkg::IDX_COMP};
      ro_l = '{mrb_pkg::IDX_PEAK, mrb_pkg::IDX_DLY0, mrb_pkg::IDX_DLY1, mrb_pkg::IDX_DLY2,
               mrb_pkg::IDX_PERIOD, mrb_pkg::IDX_NOLOAD, mrb_pkg::IDX_IA_AVG,
               mrb_pkg::IDX_VA_AVG, mrb_pkg::IDX_IB_AVG, mrb_pkg::IDX_VB_AVG,
               mrb_pkg::IDX_IC_AVG, mrb_pkg::IDX_VC_AVG, mrb_pkg::IDX_IN_AVG,
               16'he521, 16'he52f, 16'he537, 16'he5fe, 16'he604, 16'he606, 16'he609};
      mdl[mrb_pkg::IDX_NOMV] = 32'h00000000;
      mdl[mrb_pkg::IDX_LCYC] = 32'h0000ffff;
      mdl[mrb_pkg::IDX_ZXTO] = 32'h0000ffff;
      mdl[mrb_pkg::IDX_COMP] = 32'h000001ff;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values, then random writes with read-back and settings outputs
      for (int k = 0; k < 3; k++)
         foreach (rw_l[j])
         begin
            if (k > 0)
            begin
               d = $random(seed);
               wr(rw_l[j], d, r);
               chk(32'(r), 32'(mrb_pkg::RESP_OKAY));
               mdl[rw_l[j]] = d & wmask(rw_l[j]);
            end
            rd(rw_l[j], v, r);
            chk(v, mdl[rw_l[j]]);
            chk(32'(r), 32'(mrb_pkg::RESP_OKAY));
            chk({8'h00, cfg.nominal_voltage}, mdl[mrb_pkg::IDX_NOMV]);
            chk({cfg.line_cycle_count, cfg.zero_cross_timeout},
                {mdl[mrb_pkg::IDX_LCYC][15:0], mdl[mrb_pkg::IDX_ZXTO][15:0]});
            chk({16'h0000, cfg.computation_config}, mdl[mrb_pkg::IDX_COMP]);
         end
      // Read-only places refuse writes; reserved places are only read
      foreach (ro_l[j])
      begin
         er = (j < 13) ? mrb_pkg::RESP_OKAY : mrb_pkg::RESP_SLVERR;
         if (j < 13)
         begin
            wr(ro_l[j], $random(seed), r);
            chk(32'(r), 32'(mrb_pkg::RESP_SLVERR));
         end
         rd(ro_l[j], v, r);
         chk(v, exp_rd(ro_l[j]));
         chk(32'(r), 32'(er));
      end
      // Capture of the last 32-bit word moved
      foreach (rw_l[j])
         if (j < 1)
         begin
            rd(mrb_pkg::IDX_NOMV, v, r);
            rd(mrb_pkg::IDX_LAST32, d, r);
            chk(d, exp_rd(mrb_pkg::IDX_NOMV));
            rd(mrb_pkg::IDX_VB_AVG, v, r);
            rd(mrb_pkg::IDX_LAST32, d, r);
            chk(d, exp_rd(mrb_pkg::IDX_VB_AVG));
         end
      // Every nominal-enable pattern steers each phase's voltage
      for (int m = 0; m < 8; m++)
      begin
         wr(mrb_pkg::IDX_NOMEN, 32'(m), r);
         chk(32'(r), 32'(mrb_pkg::RESP_OKAY));
         chk(32'(cfg.v_used_a), m[0] ? mdl[mrb_pkg::IDX_NOMV] : 32'(meas.v_rms_a));
         chk(32'(cfg.v_used_b), m[1] ? mdl[mrb_pkg::IDX_NOMV] : 32'(meas.v_rms_b));
         chk(32'(cfg.v_used_c), m[2] ? mdl[mrb_pkg::IDX_NOMV] : 32'(meas.v_rms_c));
      end
      complete_run();
   end

endmodule

/* File: logic/mrb_pkg.sv */
// Purpose: Constants and carriers for the metering register slice
// Assumes: AXI4-Lite, 32-bit data, printed offsets are register indices
// Notes:   Byte address is four times the register index

package mrb_pkg;

   // Register indices as printed
   localparam logic [15:0] IDX_NOMV   = 16'he520;
   localparam logic [15:0] IDX_IA_AVG = 16'he530;
   localparam logic [15:0] IDX_VA_AVG = 16'he531;
   localparam logic [15:0] IDX_IB_AVG = 16'he532;
   localparam logic [15:0] IDX_VB_AVG = 16'he533;
   localparam logic [15:0] IDX_IC_AVG = 16'he534;
   localparam logic [15:0] IDX_VC_AVG = 16'he535;
   localparam logic [15:0] IDX_IN_AVG = 16'he536;
   localparam logic [15:0] IDX_LAST32 = 16'he5ff;
   localparam logic [15:0] IDX_PEAK   = 16'he600;
   localparam logic [15:0] IDX_DLY0   = 16'he601;
   localparam logic [15:0] IDX_DLY1   = 16'he602;
   localparam logic [15:0] IDX_DLY2   = 16'he603;
   localparam logic [15:0] IDX_PERIOD = 16'he607;
   localparam logic [15:0] IDX_NOLOAD = 16'he608;
   localparam logic [15:0] IDX_LCYC   = 16'he60c;
   localparam logic [15:0] IDX_ZXTO   = 16'he60d;
   localparam logic [15:0] IDX_COMP   = 16'he60e;
   localparam logic [15:0] IDX_NOMEN  = 16'he51d;

   // Widths and address split
   localparam int AW      = 18;
   localparam int IDX_LSB = 2;
   localparam int IDX_W   = 16;
   localparam int W24     = 24;
   localparam int W16     = 16;

   // Reset values
   localparam logic [23:0] RST_NOMV = 24'h000000;
   localparam logic [15:0] RST_LCYC = 16'hffff;
   localparam logic [15:0] RST_ZXTO = 16'hffff;
   localparam logic [15:0] RST_COMP = 16'h01ff;
   localparam logic [2:0]  RST_NOMEN = 3'h0;

   // Averaging window
   localparam real AVG_WINDOW_S = 1.024;
   localparam real CLK_HZ       = 10.0e6;
   localparam int  AVG_CYCLES   = int'(AVG_WINDOW_S * CLK_HZ);

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Measurement inputs from the metering core
   typedef struct packed {
      logic [23:0] i_rms_a;
      logic [23:0] v_rms_a;
      logic [23:0] i_rms_b;
      logic [23:0] v_rms_b;
      logic [23:0] i_rms_c;
      logic [23:0] v_rms_c;
      logic [23:0] i_rms_n;
      logic [15:0] peak_status;
      logic [15:0] dly0;
      logic [15:0] dly1;
      logic [15:0] dly2;
      logic [15:0] period;
      logic [15:0] noload;
   } mrb_meas_s;

   // Settings driven to the metering core
   typedef struct packed {
      logic [23:0] v_used_a;
      logic [23:0] v_used_b;
      logic [23:0] v_used_c;
      logic [23:0] nominal_voltage;
      logic [15:0] line_cycle_count;
      logic [15:0] zero_cross_timeout;
      logic [15:0] computation_config;
   } mrb_cfg_s;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_RESP = 2'b01
   } mrb_wr_e;

endpackage

/* File: logic/mrb_top.sv */
// Purpose: AXI4-Lite register slice for a polyphase metering device
// Assumes: Single clock, synchronous active-low reset
// Notes:   Unmapped or read-only writes answer SLVERR
// Overview of operation
// - Nominal-enable per phase replaces that phase's rms voltage with nominal value
// - Nominal voltage: 24-bit signed, read/write, reset zero, sent as 32
// - Averaged rms registers: read-only 24-bit, 1.024 s average per channel
// - Keep data of last successful 32-bit transfer, read-only
// - Line-cycle count: 16-bit read/write, resets to all ones
// - Zero-crossing timeout: 16-bit read/write, resets to all ones
// - Computation-mode: 16-bit read/write, resets to 0x01ff
// - Three read-only 16-bit inter-phase delay registers
// - Read-only 16-bit phase peak status register
// - Read-only 16-bit phase no-load status register
// - Each register moves with a fixed transfer length of 32 or 16 bits
`timescale 1ns/100ps

module mrb_top #(
   parameter int AVG_LEN = mrb_pkg::AVG_CYCLES
) (
   // Clock and reset
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   // AXI4-Lite write
   input  wire logic [mrb_pkg::AW-1:0]  s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   // AXI4-Lite read
   input  wire logic [mrb_pkg::AW-1:0]  s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   // Metering core
   input  wire mrb_pkg::mrb_meas_s      meas,
   input  wire logic [2:0]              applied_voltage_rms_in,
   output mrb_pkg::mrb_cfg_s            cfg
);

   // All state in one struct
   typedef struct packed {
      logic [1:0]  wst;
      logic [mrb_pkg::IDX_W-1:0] widx;
      logic        aw_got;
      logic [31:0] wdat;
      logic [3:0]  wstb;
      logic        w_got;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [23:0] nomv;
      logic [2:0]  nomen;
      logic [15:0] lcyc;
      logic [15:0] zxto;
      logic [15:0] comp;
      logic [31:0] last32;
      logic [7*24-1:0] avg;
      logic [7*48-1:0] acc;
      logic [31:0] cnt;
   } mrb_state_s;

   mrb_state_s st_r;
   mrb_state_s st_nxt;
   logic [23:0] v_live [3];

   // Byte-lane merge of a write onto a stored value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] stb);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++)
      begin
         if (stb[b])
         begin
            m[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return m;
   endfunction

   // Byte address to register index
   function automatic logic [mrb_pkg::IDX_W-1:0] to_idx(input logic [mrb_pkg::AW-1:0] a);
      return a[mrb_pkg::IDX_LSB +: mrb_pkg::IDX_W];
   endfunction

   // Write decode: is the index a writable register
   function automatic logic is_rw(input logic [mrb_pkg::IDX_W-1:0] i);
      return (i == mrb_pkg::IDX_NOMV) || (i == mrb_pkg::IDX_LCYC) ||
             (i == mrb_pkg::IDX_ZXTO) || (i == mrb_pkg::IDX_COMP) ||
             (i == mrb_pkg::IDX_NOMEN);
   endfunction

   // Raw rms channel for the averagers
   function automatic logic [23:0] raw_ch(input mrb_pkg::mrb_meas_s m, input int k);
      unique case (k)
         0: return m.i_rms_a;
         1: return m.v_rms_a;
         2: return m.i_rms_b;
         3: return m.v_rms_b;
         4: return m.i_rms_c;
         5: return m.v_rms_c;
         default: return m.i_rms_n;
      endcase
   endfunction

   // Read mux; narrow values padded with zeros
   function automatic logic [32:0] rd_mux(input mrb_state_s s, input mrb_pkg::mrb_meas_s m,
                                          input logic [mrb_pkg::IDX_W-1:0] i);
      logic [32:0] r;
      r = {1'b1, 32'h00000000};
      if (i == mrb_pkg::IDX_NOMV)        r = {1'b0, 8'h00, s.nomv};
      else if (i == mrb_pkg::IDX_NOMEN)  r = {1'b0, 29'h00000000, s.nomen};
      else if (i >= mrb_pkg::IDX_IA_AVG && i <= mrb_pkg::IDX_IN_AVG)
         r = {1'b0, 8'h00, s.avg[(i - mrb_pkg::IDX_IA_AVG)*24 +: 24]};
      else if (i == mrb_pkg::IDX_LAST32) r = {1'b0, s.last32};
      else if (i == mrb_pkg::IDX_PEAK)   r = {1'b0, 16'h0000, m.peak_status};
      else if (i == mrb_pkg::IDX_DLY0)   r = {1'b0, 16'h0000, m.dly0};
      else if (i == mrb_pkg::IDX_DLY1)   r = {1'b0, 16'h0000, m.dly1};
      else if (i == mrb_pkg::IDX_DLY2)   r = {1'b0, 16'h0000, m.dly2};
      else if (i == mrb_pkg::IDX_PERIOD) r = {1'b0, 16'h0000, m.period};
      else if (i == mrb_pkg::IDX_NOLOAD) r = {1'b0, 16'h0000, m.noload};
      else if (i == mrb_pkg::IDX_LCYC)   r = {1'b0, 16'h0000, s.lcyc};
      else if (i == mrb_pkg::IDX_ZXTO)   r = {1'b0, 16'h0000, s.zxto};
      else if (i == mrb_pkg::IDX_COMP)   r = {1'b0, 16'h0000, s.comp};
      return r;
   endfunction

   // Live applied voltages per phase
   assign v_live[0] = meas.v_rms_a;
   assign v_live[1] = meas.v_rms_b;
   assign v_live[2] = meas.v_rms_c;

   // Handshake outputs
   assign s_axi_awready = (st_r.wst == mrb_pkg::WR_IDLE) && !st_r.aw_got;
   assign s_axi_wready  = (st_r.wst == mrb_pkg::WR_IDLE) && !st_r.w_got;
   assign s_axi_bvalid  = (st_r.wst == mrb_pkg::WR_RESP);
   assign s_axi_bresp   = st_r.bresp;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_rvalid  = st_r.rvalid;
   assign s_axi_rdata   = st_r.rdata;
   assign s_axi_rresp   = st_r.rresp;

   // Settings to the core
   always_comb
   begin
      cfg.v_used_a           = st_r.nomen[0] ? st_r.nomv : v_live[0];
      cfg.v_used_b           = st_r.nomen[1] ? st_r.nomv : v_live[1];
      cfg.v_used_c           = st_r.nomen[2] ? st_r.nomv : v_live[2];
      cfg.nominal_voltage    = st_r.nomv;
      cfg.line_cycle_count   = st_r.lcyc;
      cfg.zero_cross_timeout = st_r.zxto;
      cfg.computation_config = st_r.comp;
   end

   // Next-state logic
   always_comb
   begin
      logic [32:0] rd;
      logic [31:0] mw;
      logic        win;
      logic [mrb_pkg::IDX_W-1:0] ri;
      rd     = '0;
      mw     = '0;
      win    = 1'b0;
      ri     = '0;
      st_nxt = st_r;
      // Accept address and data in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
         st_nxt.aw_got = 1'b1;
         st_nxt.widx   = to_idx(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdat  = s_axi_wdata;
         st_nxt.wstb  = s_axi_wstrb;
      end
      unique case (st_r.wst)
         mrb_pkg::WR_IDLE:
         begin
            if (st_r.aw_got && st_r.w_got)
            begin
               st_nxt.aw_got = 1'b0;
               st_nxt.w_got  = 1'b0;
               st_nxt.wst    = mrb_pkg::WR_RESP;
               if (!is_rw(st_r.widx))
               begin
                  st_nxt.bresp = mrb_pkg::RESP_SLVERR;
               end
               else
               begin
                  st_nxt.bresp = mrb_pkg::RESP_OKAY;
                  mw = merge(32'h00000000, st_r.wdat, st_r.wstb);
                  unique case (st_r.widx)
                     mrb_pkg::IDX_NOMV:
                     begin
                        mw = merge({8'h00, st_r.nomv}, st_r.wdat, st_r.wstb);
                        st_nxt.nomv = mw[mrb_pkg::W24-1:0];
                        st_nxt.last32 = {8'h00, mw[mrb_pkg::W24-1:0]};
                     end
                     mrb_pkg::IDX_NOMEN:
                     begin
                        mw = merge({29'h00000000, st_r.nomen}, st_r.wdat, st_r.wstb);
                        st_nxt.nomen = mw[2:0];
                     end
                     mrb_pkg::IDX_LCYC:
                     begin
                        mw = merge({16'h0000, st_r.lcyc}, st_r.wdat, st_r.wstb);
                        st_nxt.lcyc = mw[mrb_pkg::W16-1:0];
                     end
                     mrb_pkg::IDX_ZXTO:
                     begin
                        mw = merge({16'h0000, st_r.zxto}, st_r.wdat, st_r.wstb);
                        st_nxt.zxto = mw[mrb_pkg::W16-1:0];
                     end
                     default:
                     begin
                        mw = merge({16'h0000, st_r.comp}, st_r.wdat, st_r.wstb);
                        st_nxt.comp = mw[mrb_pkg::W16-1:0];
                     end
                  endcase
               end
            end
         end
         default:
         begin
            if (s_axi_bready)
            begin
               st_nxt.wst = mrb_pkg::WR_IDLE;
            end
         end
      endcase
      // Read channel: one cycle to data
      if (s_axi_arvalid && s_axi_arready)
      begin
         ri            = to_idx(s_axi_araddr);
         rd            = rd_mux(st_r, meas, ri);
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = rd[31:0];
         st_nxt.rresp  = rd[32] ? mrb_pkg::RESP_SLVERR : mrb_pkg::RESP_OKAY;
         if (!rd[32] && (ri == mrb_pkg::IDX_NOMV || ri == mrb_pkg::IDX_LAST32 ||
             (ri >= mrb_pkg::IDX_IA_AVG && ri <= mrb_pkg::IDX_IN_AVG)))
         begin
            st_nxt.last32 = rd[31:0];
         end
      end
      else if (st_r.rvalid && s_axi_rready)
      begin
         st_nxt.rvalid = 1'b0;
      end
      win = (st_r.cnt == 32'(AVG_LEN - 1));
      st_nxt.cnt = win ? 32'h00000000 : st_r.cnt + 32'h00000001;
      for (int k = 0; k < 7; k++)
      begin
         if (win)
         begin
            // Signed divide: negative averages stay right for windows up to 2^24 samples, where the 48-bit sum cannot overflow
            st_nxt.avg[k*24 +: 24] = 24'($signed(st_r.acc[k*48 +: 48] +
                                     48'(signed'(raw_ch(meas, k)))) / $signed(48'(AVG_LEN)));
            st_nxt.acc[k*48 +: 48] = 48'h000000000000;
         end
         else
         begin
            st_nxt.acc[k*48 +: 48] = st_r.acc[k*48 +: 48] +
                                     48'(signed'(raw_ch(meas, k)));
         end
      end
      // Reset values
      if (!aresetn)
      begin
         st_nxt        = '0;
         st_nxt.wst    = mrb_pkg::WR_IDLE;
         st_nxt.nomv   = mrb_pkg::RST_NOMV;
         st_nxt.nomen  = mrb_pkg::RST_NOMEN;
         st_nxt.lcyc   = mrb_pkg::RST_LCYC;
         st_nxt.zxto   = mrb_pkg::RST_ZXTO;
         st_nxt.comp   = mrb_pkg::RST_COMP;
      end
   end

   // State register, synchronous reset folded in above
   always_ff @(posedge aclk)
   begin
      st_r <= st_nxt;
   end

   // Assertions
   a_lcyc_reset: assert property (@(posedge aclk) !aresetn |=> st_r.lcyc == mrb_pkg::RST_LCYC)
      else $error("line cycle count reset wrong");
   a_zxto_reset: assert property (@(posedge aclk) !aresetn |=> st_r.zxto == mrb_pkg::RST_ZXTO)
      else $error("zero cross timeout reset wrong");
   a_comp_reset: assert property (@(posedge aclk) !aresetn |=> st_r.comp == mrb_pkg::RST_COMP)
      else $error("computation mode reset wrong");
   a_nomv_reset: assert property (@(posedge aclk) !aresetn |=> st_r.nomv == mrb_pkg::RST_NOMV)
      else $error("nominal voltage reset wrong");
   a_nom_subst: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.nomen[0] |-> cfg.v_used_a == st_r.nomv)
      else $error("nominal voltage not substituted");
   a_narrow_pad: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && to_idx(s_axi_araddr) == mrb_pkg::IDX_PEAK
      |=> s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[15:0] == $past(meas.peak_status))
      else $error("peak status read wrong");
   a_dly_read: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && to_idx(s_axi_araddr) == mrb_pkg::IDX_DLY1
      |=> s_axi_rdata == {16'h0000, $past(meas.dly1)})
      else $error("delay read wrong");
   a_noload_rd: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && to_idx(s_axi_araddr) == mrb_pkg::IDX_NOLOAD
      |=> s_axi_rdata[31:16] == 16'h0000 && s_axi_rresp == 2'h0)
      else $error("no-load read wrong");
   a_avg_pad: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && to_idx(s_axi_araddr) == mrb_pkg::IDX_IA_AVG
      |=> s_axi_rdata[31:24] == 8'h00)
      else $error("average upper bits not zero");
   a_last_rd: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && to_idx(s_axi_araddr) == mrb_pkg::IDX_NOMV
      |=> ##1 st_r.last32 == $past(s_axi_rdata, 1))
      else $error("last word not captured");
   a_rsvd_write: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.wst == mrb_pkg::WR_IDLE && st_r.aw_got && st_r.w_got && !is_rw(st_r.widx)
      |=> s_axi_bvalid && s_axi_bresp == 2'h2 && $stable(st_r.comp))
      else $error("reserved write not refused");
   a_width_fix: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && to_idx(s_axi_araddr) == mrb_pkg::IDX_COMP
      |=> s_axi_rdata[31:16] == 16'h0000)
      else $error("16-bit transfer not padded");
   a_pad_nomv: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && to_idx(s_axi_araddr) == mrb_pkg::IDX_NOMV
      |=> s_axi_rdata == {8'h00, $past(st_r.nomv)})
      else $error("nominal voltage read not zero padded");
   // Live voltage passes only while the phase's nominal bit is clear
   a_live_pass: assert property (@(posedge aclk) disable iff (!aresetn)
      !st_r.nomen[1] |-> cfg.v_used_b == meas.v_rms_b)
      else $error("live voltage not passed through");
   a_nom_phase_c: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.nomen[2] |-> cfg.v_used_c == st_r.nomv)
      else $error("phase c nominal not substituted");
   a_last_wr: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.wst == mrb_pkg::WR_IDLE && st_r.aw_got && st_r.w_got && st_r.widx == mrb_pkg::IDX_NOMV
      |=> st_r.last32 == {8'h00, st_r.nomv})
      else $error("nominal write not captured");

   c_write_ok: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0);
   c_write_err: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bresp == 2'h2);
   c_read_ok: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
   c_subst: cover property (@(posedge aclk) st_r.nomen == 3'h7);
   c_avg_update: cover property (@(posedge aclk) st_r.cnt == 32'(AVG_LEN - 1));

endmodule
